/* File: hdl/dcc_pkg.sv */
// constants for the core control word register block
package dcc_pkg;
  localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
  localparam logic [31:0] DEPTH_OFFSET  = 32'h0000_0004;
  localparam int          ADDR_W        = 4;
  localparam int          BIT_MUL_UNS   = 12;
  localparam int          BIT_EARLY     = 11;
  localparam int          BIT_DEPTH_LO  = 8;
  localparam int          BIT_SAT_A     = 7;
  localparam int          BIT_SAT_B     = 6;
  localparam int          BIT_SAT_MEM   = 5;
  localparam int          BIT_SAT_MODE  = 4;
  localparam int          BIT_PRIO3     = 3;
  localparam int          BIT_WINDOW    = 2;
  localparam int          BIT_ROUND     = 1;
  localparam int          BIT_FRAC      = 0;
  localparam logic [15:0] CTRL_RESET    = 16'h0020;
  localparam logic [15:0] WRITE_MASK    = 16'h10F7;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    DCC_IDLE = 2'b00,
    DCC_RESP = 2'b01
  } dcc_wr_e;
endpackage : dcc_pkg

/* File: hdl/dcc_core_control.sv */
// core control word register with axi4-lite slave
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module dcc_core_control (
  input  wire logic        CLK,             // 125 MHz core clock
  input  wire logic        RST_N,           // async reset, active low
  input  wire logic [31:0] S_AXI_AWADDR,    // write address
  input  wire logic        S_AXI_AWVALID,   // write address valid
  output logic             S_AXI_AWREADY,   // write address ready
  input  wire logic [31:0] S_AXI_WDATA,     // write data
  input  wire logic [3:0]  S_AXI_WSTRB,     // write byte strobes
  input  wire logic        S_AXI_WVALID,    // write data valid
  output logic             S_AXI_WREADY,    // write data ready
  output logic [1:0]       S_AXI_BRESP,     // write response
  output logic             S_AXI_BVALID,    // write response valid
  input  wire logic        S_AXI_BREADY,    // write response ready
  input  wire logic [31:0] S_AXI_ARADDR,    // read address
  input  wire logic        S_AXI_ARVALID,   // read address valid
  output logic             S_AXI_ARREADY,   // read address ready
  output logic [31:0]      S_AXI_RDATA,     // read data
  output logic [1:0]       S_AXI_RRESP,     // read response
  output logic             S_AXI_RVALID,    // read data valid
  input  wire logic        S_AXI_RREADY,    // read data ready
  input  wire logic [2:0]  LOOP_DEPTH_IN,   // active loop count from loop hw
  input  wire logic        PRIO_BIT3_SET,   // priority above seven, level
  output logic             SAT_A_EN,        // acc a saturation enable
  output logic             SAT_B_EN,        // acc b saturation enable
  output logic             SAT_MEM_EN,      // data write saturation enable
  output logic             SAT_MODE,        // 1 = 9.31 super saturation
  output logic             PRIORITY_BIT3,   // priority level bit three
  output logic             PROG_WINDOW_EN,  // program window visible
  output logic             ROUND_MODE,      // 1 = conventional rounding
  output logic             FRAC_MODE,       // 1 = integer, 0 = fractional
  output logic             MUL_UNSIGNED,    // 1 = unsigned multiplies
  output logic             EARLY_TERM       // end innermost loop, pulse
);
  logic            mul_uns;
  logic            sat_a;
  logic            sat_b;
  logic            sat_mem;
  logic            sat_mode;
  logic            prio3;
  logic            window;
  logic            round;
  logic            frac;
  logic [2:0]      depth;
  logic            aw_held;
  logic            w_held;
  logic [31:0]     aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  dcc_pkg::dcc_wr_e wr_state;
  logic            early;
  logic [31:0]     rdata;
  logic [1:0]      rresp;
  logic            rvalid;
  logic [1:0]      bresp;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a[dcc_pkg::ADDR_W-1:2] == off[dcc_pkg::ADDR_W-1:2]) &&
          (a[31:dcc_pkg::ADDR_W] == '0);
  endfunction : hit

  // one writable bit: its byte lane must be strobed and the bit be in the mask
  function automatic logic field_next(input logic        old,
                                      input int          pos,
                                      input logic [15:0] data,
                                      input logic        lo,
                                      input logic        hi);
    logic take;
    take       = dcc_pkg::WRITE_MASK[pos] && ((pos < 8) ? lo : hi);
    field_next = take ? data[pos] : old;
  endfunction : field_next

  wire        wr_go   = (wr_state == dcc_pkg::DCC_IDLE) && aw_held && w_held;
  wire        wr_ctrl = wr_go && hit(aw_addr, dcc_pkg::CTRL_OFFSET);
  wire        wr_ok   = wr_ctrl || (wr_go && hit(aw_addr, dcc_pkg::DEPTH_OFFSET));
  wire        lo_en   = wr_ctrl && w_strb[0];
  wire        hi_en   = wr_ctrl && w_strb[1];
  wire [15:0] wr_word = w_data[15:0];
  // priority bit three is clear-only; hardware set wins over a same-cycle clear
  wire        prio3_clr  = lo_en && !wr_word[dcc_pkg::BIT_PRIO3];
  wire        next_prio3 = PRIO_BIT3_SET || (prio3 && !prio3_clr);
  wire        next_mul_uns  = field_next(mul_uns, dcc_pkg::BIT_MUL_UNS, wr_word, lo_en, hi_en);
  wire        next_sat_a    = field_next(sat_a, dcc_pkg::BIT_SAT_A, wr_word, lo_en, hi_en);
  wire        next_sat_b    = field_next(sat_b, dcc_pkg::BIT_SAT_B, wr_word, lo_en, hi_en);
  wire        next_sat_mem  = field_next(sat_mem, dcc_pkg::BIT_SAT_MEM, wr_word, lo_en, hi_en);
  wire        next_sat_mode = field_next(sat_mode, dcc_pkg::BIT_SAT_MODE, wr_word, lo_en, hi_en);
  wire        next_window   = field_next(window, dcc_pkg::BIT_WINDOW, wr_word, lo_en, hi_en);
  wire        next_round    = field_next(round, dcc_pkg::BIT_ROUND, wr_word, lo_en, hi_en);
  wire        next_frac     = field_next(frac, dcc_pkg::BIT_FRAC, wr_word, lo_en, hi_en);
  // bit eleven always reads zero; only a written one makes the pulse
  wire        next_early    = hi_en && wr_word[dcc_pkg::BIT_EARLY];
  wire [15:0] readback = {
    3'h0,
    mul_uns,
    1'b0,
    depth,
    sat_a,
    sat_b,
    sat_mem,
    sat_mode,
    prio3,
    window,
    round,
    frac
  };
  wire        ar_ok = hit(S_AXI_ARADDR, dcc_pkg::CTRL_OFFSET) ||
                      hit(S_AXI_ARADDR, dcc_pkg::DEPTH_OFFSET);

  assign S_AXI_AWREADY = !aw_held && (wr_state == dcc_pkg::DCC_IDLE);
  assign S_AXI_WREADY  = !w_held && (wr_state == dcc_pkg::DCC_IDLE);
  assign S_AXI_BVALID  = (wr_state == dcc_pkg::DCC_RESP);
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RDATA   = rdata;
  assign S_AXI_RRESP   = rresp;

  assign SAT_A_EN       = sat_a;
  assign SAT_B_EN       = sat_b;
  assign SAT_MEM_EN     = sat_mem;
  assign SAT_MODE       = sat_mode;
  assign PRIORITY_BIT3  = prio3;
  assign PROG_WINDOW_EN = window;
  assign ROUND_MODE     = round;
  assign FRAC_MODE      = frac;
  assign MUL_UNSIGNED   = mul_uns;
  assign EARLY_TERM     = early;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mul_uns <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_MUL_UNS];
    end else begin
      mul_uns <= next_mul_uns;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sat_a <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_SAT_A];
    end else begin
      sat_a <= next_sat_a;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sat_b <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_SAT_B];
    end else begin
      sat_b <= next_sat_b;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sat_mem <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_SAT_MEM];
    end else begin
      sat_mem <= next_sat_mem;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sat_mode <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_SAT_MODE];
    end else begin
      sat_mode <= next_sat_mode;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prio3 <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_PRIO3];
    end else begin
      prio3 <= next_prio3;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      window <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_WINDOW];
    end else begin
      window <= next_window;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      round <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_ROUND];
    end else begin
      round <= next_round;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frac <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_FRAC];
    end else begin
      frac <= next_frac;
    end
  end

  // depth lags the loop hardware by one clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      depth <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_DEPTH_LO +: 3];
    end else begin
      depth <= LOOP_DEPTH_IN;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      early <= dcc_pkg::CTRL_RESET[dcc_pkg::BIT_EARLY];
    end else begin
      early <= next_early;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_state <= dcc_pkg::DCC_IDLE;
      bresp <= dcc_pkg::RESP_OKAY;
    end else begin
      case (wr_state)
        dcc_pkg::DCC_IDLE: begin
          if (wr_go) begin
            wr_state <= dcc_pkg::DCC_RESP;
            bresp <= wr_ok ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
          end
        end
        dcc_pkg::DCC_RESP: begin
          if (S_AXI_BREADY) begin
            wr_state <= dcc_pkg::DCC_IDLE;
          end
        end
        default: wr_state <= dcc_pkg::DCC_IDLE;
      endcase
    end
  end

  // both offsets return the whole word; the second is a read alias
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= dcc_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid <= 1'b1;
      rdata <= ar_ok ? {16'h0000, readback} : 32'h0000_0000;
      rresp <= ar_ok ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end
endmodule : dcc_core_control
`default_nettype wire

/* File: bench/dcc_monitor.sv */
// concurrent checks on the core control word register ports
`timescale 1ns/10ps
`default_nettype none
module dcc_monitor (
  input wire logic        CLK,           // core clock
  input wire logic        RST_N,         // async reset, active low
  input wire logic        S_AXI_ARREADY, // read address ready
  input wire logic [31:0] S_AXI_RDATA,   // read data
  input wire logic [1:0]  S_AXI_RRESP,   // read response
  input wire logic        S_AXI_RVALID,  // read data valid
  input wire logic        S_AXI_BVALID,  // write response valid
  input wire logic [2:0]  LOOP_DEPTH_IN, // active loop count
  input wire logic        PRIO_BIT3_SET, // priority set request
  input wire logic        PRIORITY_BIT3, // priority bit three
  input wire logic        SAT_A_EN,      // acc a saturation
  input wire logic        SAT_MEM_EN,    // memory write saturation
  input wire logic        EARLY_TERM     // loop end pulse
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  depth_read_a: assert property ($rose(S_AXI_RVALID) && S_AXI_RRESP == 2'h0
    |-> S_AXI_RDATA[10:8] == $past(LOOP_DEPTH_IN, 2)) else $error("depth field wrong");
  prio_set_a: assert property (PRIO_BIT3_SET |=> PRIORITY_BIT3)
    else $error("bit three not set");
  prio_quiet_a: assert property ($fell(PRIORITY_BIT3) |-> $rose(S_AXI_BVALID))
    else $error("bit three cleared without write");
  sat_quiet_a: assert property ($changed(SAT_A_EN) |-> $rose(S_AXI_BVALID))
    else $error("acc a enable moved without write");
  mem_quiet_a: assert property ($changed(SAT_MEM_EN) |-> $rose(S_AXI_BVALID))
    else $error("memory enable moved without write");
  early_pulse_a: assert property (EARLY_TERM |=> !EARLY_TERM) else $error("pulse too long");
  rd_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:13] == 19'h0
    && !S_AXI_RDATA[11]) else $error("reserved read bits set");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read overlap");
endmodule : dcc_monitor
bind dcc_core_control dcc_monitor mon (.CLK, .RST_N, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_BVALID, .LOOP_DEPTH_IN, .PRIO_BIT3_SET,
  .PRIORITY_BIT3, .SAT_A_EN, .SAT_MEM_EN, .EARLY_TERM);
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the core control word register
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  logic CLK = 0, RST_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, PRIO_BIT3_SET = 0, S_AXI_AWREADY, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, SAT_A_EN, SAT_B_EN, SAT_MEM_EN, SAT_MODE;
  logic PRIORITY_BIT3, PROG_WINDOW_EN, ROUND_MODE, FRAC_MODE, MUL_UNSIGNED, EARLY_TERM;
  logic [31:0] S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 0;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [2:0]  LOOP_DEPTH_IN = 0;
  int          errors = 0, n_tests = 0, pulses = 0;
  dcc_core_control uut (.*);
  always #4 CLK = ~CLK;
  // counted mid-cycle so the registered pulse has settled
  always @(negedge CLK) if (EARLY_TERM === 1'b1) pulses++;
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] r);
    int n;
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_WSTRB   <= s;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID  <= 1;
    S_AXI_BREADY  <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
      if (S_AXI_BVALID) break;
    end
    S_AXI_BREADY <= 0;
    if (n == 50) begin errors++; end_of_test; end
    `CHK("bresp", r, S_AXI_BRESP)
    // one edge between calls, so bready is never assigned twice in a step
    @(posedge CLK);
  endtask : wr
  // pins are compared with the read value, long after the write landed
  task automatic rd(input logic [31:0] a, e, input logic [1:0] r);
    int n;
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY  <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
      if (S_AXI_RVALID) break;
    end
    S_AXI_RREADY <= 0;
    if (n == 50) begin errors++; end_of_test; end
    `CHK("rdata", e, S_AXI_RDATA)
    `CHK("rresp", r, S_AXI_RRESP)
    if (r == 2'h0) `CHK("pins", {e[12], e[7:0]}, {MUL_UNSIGNED, SAT_A_EN, SAT_B_EN,
      SAT_MEM_EN, SAT_MODE, PRIORITY_BIT3, PROG_WINDOW_EN, ROUND_MODE, FRAC_MODE})
    @(posedge CLK);
  endtask : rd
  initial begin
    repeat (20) @(posedge CLK);
    RST_N <= 1;
    @(posedge CLK);
    rd(32'h0, 32'h20, 2'h0);
    wr(32'h0, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd(32'h0, 32'h10F7, 2'h0);
    `CHK("pulse", 1, pulses)
    wr(32'h4, 32'h0800, 4'h1, 2'h0);
    rd(32'h4, 32'h10F7, 2'h0);
    wr(32'h0, 32'h10F7, 4'h3, 2'h0);
    `CHK("pulse", 1, pulses)
    wr(32'h8, 32'h0, 4'h3, 2'h2);
    rd(32'h8, 32'h0, 2'h2);
    rd(32'h0, 32'h10F7, 2'h0);
    PRIO_BIT3_SET <= 1;
    @(posedge CLK);
    PRIO_BIT3_SET <= 0;
    wr(32'h0, 32'h08, 4'h1, 2'h0);
    rd(32'h0, 32'h1008, 2'h0);
    PRIO_BIT3_SET <= 1;
    wr(32'h0, 32'h0, 4'h1, 2'h0);
    PRIO_BIT3_SET <= 0;
    rd(32'h0, 32'h1008, 2'h0);
    wr(32'h0, 32'h0, 4'h1, 2'h0);
    rd(32'h0, 32'h1000, 2'h0);
    for (int d = 0; d < 8; d++) begin
      LOOP_DEPTH_IN <= 3'(d);
      repeat (2) @(posedge CLK);
      rd(32'h0, 32'h1000 | (d << 8), 2'h0);
    end
    wr(32'h0, 32'h0, 4'h2, 2'h0);
    rd(32'h0, 32'h0700, 2'h0);
    end_of_test;
  end
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule : tb
`default_nettype wire
